// ### rtl/hut_regs.svh
// Timing and sizing constants for the host serial transport
`ifndef HUT_REGS_SVH
`define HUT_REGS_SVH
`define HUT_CLK_HZ        20000000
`define HUT_BAUD_DEFAULT  115200
`define HUT_BAUD_MIN      9600
`define HUT_BAUD_MAX      4000000
`define HUT_DIV_DEFAULT   ((`HUT_CLK_HZ + `HUT_BAUD_DEFAULT / 2) / `HUT_BAUD_DEFAULT)
`define HUT_DIV_MIN       (`HUT_CLK_HZ / `HUT_BAUD_MAX)
`define HUT_DIV_MAX       ((`HUT_CLK_HZ + `HUT_BAUD_MIN - 1) / `HUT_BAUD_MIN)
`define HUT_FIFO_DEPTH    1040
`define HUT_RTS_MARGIN    16
`define HUT_HUNT_BITS     10
`define HUT_FRAME_BITS    9
`endif

// ### rtl/hut_pkg.sv
// Types shared by the host serial transport
package hut_pkg;
	// Packet transport selected by the controller
	typedef enum logic [1:0] {
		HUT_H4  = 2'b00,
		HUT_H4X = 2'b01,
		HUT_H5  = 2'b10
	} hut_mode_e;
	// Receiver states
	typedef enum logic [2:0] {
		RX_IDLE    = 3'b000,
		RX_START   = 3'b001,
		RX_DATA    = 3'b010,
		RX_STOP    = 3'b011,
		RX_MEASURE = 3'b100,
		RX_HUNT    = 3'b101
	} hut_rx_e;
	// Transmitter states
	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} hut_tx_e;
	// Current rate selection
	typedef struct packed {
		logic        detected;
		logic [15:0] divisor;
	} hut_baud_s;
endpackage : hut_pkg

// ### rtl/hut_transport.sv
// Host serial transport: flow-controlled serial port with autobaud and two queues
`timescale 1ns/1ps
`include "hut_regs.svh"

module hut_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `HUT_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst,
	// Filling side
	input  wire logic                       inValid,
	input  wire logic [WIDTH-1:0]           inData,
	output logic                            inReady,
	// Draining side
	output logic                            outValid,
	output logic [WIDTH-1:0]                outData,
	input  wire logic                       outReady,
	// Fill level of the storage array
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];   // Flop storage
	logic [AW-1:0]    wrPtr;         // Next slot to write
	logic [AW-1:0]    rdPtr;         // Next slot to read

	// Handshakes and next fill level
	wire          doPush     = inValid && inReady;
	wire          doPull     = (level != '0) && (!outValid || outReady);
	wire [CW-1:0] next_level = level + CW'(doPush) - CW'(doPull);
	wire [AW-1:0] next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
	wire [AW-1:0] next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;

	// Storage needs no reset, so it sits apart
	always_ff @(posedge clock) begin
		if (doPush) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers, level and the registered output stage
	always_ff @(posedge clock) begin
		if (rst) begin
			wrPtr    <= '0;
			rdPtr    <= '0;
			level    <= '0;
			inReady  <= 1'b1;
			outValid <= 1'b0;
			outData  <= '0;
		end else begin
			if (doPush) begin
				wrPtr <= next_wrPtr;
			end
			if (doPull) begin
				rdPtr    <= next_rdPtr;
				outData  <= mem[rdPtr];
				outValid <= 1'b1;
			end else if (outReady) begin
				outValid <= 1'b0;
			end
			level   <= next_level;
			// Ready from the next level keeps full honest
			inReady <= (next_level < CW'(DEPTH));
		end
	end
endmodule : hut_fifo

module hut_transport #(
	parameter int DEPTH      = `HUT_FIFO_DEPTH,
	parameter int RTS_MARGIN = `HUT_RTS_MARGIN
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// Serial pins
	input  wire logic              hciSerialIn,
	input  wire logic              hciTxFlowPermitN,
	output logic                   hciSerialOut,
	output logic                   hciRxFlowReadyN,
	// Rate and transport control from the controller
	input  hut_pkg::hut_mode_e     transportMode,
	input  wire logic              baudWrite,
	input  wire logic [15:0]       baudDivisorIn,
	output hut_pkg::hut_baud_s     baudStatus,
	// Transmit stream from the controller
	input  wire logic              txValid,
	input  wire logic [7:0]        txData,
	output logic                   txReady,
	// Receive stream to the controller
	output logic                   rxValid,
	output logic [7:0]             rxData,
	input  wire logic              rxReady,
	// Receive error pulses
	output logic                   rxFrameError,
	output logic                   rxOverrun
);
	localparam int LW = $clog2(DEPTH + 1);

	// Pin synchronisers and filtered levels
	logic [2:0]          rxSync;        // Serial input chain
	logic [2:0]          ctsSync;       // Permit input chain
	logic                rxLine;        // Filtered serial input
	logic                rxLinePrev;    // For edge detection
	logic                permitN;       // Filtered permit
	// Rate selection
	logic                autoArmed;     // Autobaud still waiting
	// Transmitter
	hut_pkg::hut_tx_e    txState;
	logic [15:0]         txCnt;
	logic [3:0]          txBits;
	logic [8:0]          txShift;
	// Receiver
	hut_pkg::hut_rx_e    rxState;
	logic [19:0]         rxCnt;
	logic [3:0]          rxBits;
	logic [7:0]          rxShift;
	logic                rxPush;        // One-cycle push into receive queue
	// Queue wiring
	logic                txqValid;
	logic [7:0]          txqData;
	logic                rxqReady;
	logic [LW-1:0]       rxLevel;
	logic [LW-1:0]       txLevelUnused;

	// Divisor and derived compare points
	wire [15:0] div       = baudStatus.divisor;
	wire [19:0] bitEnd    = 20'(div) - 20'd1;
	wire [19:0] halfBit   = 20'(div[15:1]);
	wire [19:0] huntLimit = 20'(div) * 20'(`HUT_HUNT_BITS);
	wire        txBitEnd  = (txCnt == div - 16'd1);
	wire        rxBitEnd  = (rxCnt == bitEnd);
	// Flow lines are ignored in the three-wire mode
	wire        isH5      = (transportMode == hut_pkg::HUT_H5);
	wire        permitted = isH5 || !permitN;
	wire        txTake    = (txState == hut_pkg::TX_IDLE) && txqValid && permitted;
	wire        rxFall    = rxLinePrev && !rxLine;
	// Written divisor checked against the supported range
	wire        inRange   = (baudDivisorIn >= 16'(`HUT_DIV_MIN)) && (baudDivisorIn <= 16'(`HUT_DIV_MAX));
	wire        measOk    = (rxCnt >= 20'(`HUT_DIV_MIN)) && (rxCnt <= 20'(`HUT_DIV_MAX));
	wire        nearFull  = (rxLevel >= LW'(DEPTH - RTS_MARGIN));

	// Transmit queue: controller fills, shifter drains
	hut_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txQueue (
		.clock    (clock),
		.rst      (rst),
		.inValid  (txValid),
		.inData   (txData),
		.inReady  (txReady),
		.outValid (txqValid),
		.outData  (txqData),
		.outReady (txTake),
		.level    (txLevelUnused)
	);

	// Receive queue: shifter fills, controller drains
	hut_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rxQueue (
		.clock    (clock),
		.rst      (rst),
		.inValid  (rxPush),
		.inData   (rxShift),
		.inReady  (rxqReady),
		.outValid (rxValid),
		.outData  (rxData),
		.outReady (rxReady),
		.level    (rxLevel)
	);

	// Three-flop synchronisers, change taken when the last two agree
	always_ff @(posedge clock) begin
		if (rst) begin
			rxSync     <= 3'h7;
			ctsSync    <= 3'h7;
			rxLine     <= 1'b1;
			rxLinePrev <= 1'b1;
			permitN    <= 1'b1;
		end else begin
			rxSync     <= {rxSync[1:0], hciSerialIn};
			ctsSync    <= {ctsSync[1:0], hciTxFlowPermitN};
			rxLinePrev <= rxLine;
			if (rxSync[1] == rxSync[2]) begin
				rxLine <= rxSync[2];
			end
			if (ctsSync[1] == ctsSync[2]) begin
				permitN <= ctsSync[2];
			end
		end
	end

	// Rate selection: default, then autobaud or controller write
	always_ff @(posedge clock) begin
		if (rst) begin
			baudStatus.divisor  <= 16'(`HUT_DIV_DEFAULT);
			baudStatus.detected <= 1'b0;
			autoArmed           <= 1'b1;
		end else if (baudWrite) begin
			// Out of range writes are dropped, the rate keeps running
			if (inRange) begin
				baudStatus.divisor <= baudDivisorIn;
				autoArmed          <= 1'b0;
			end
		end else if (rxState == hut_pkg::RX_MEASURE && rxLine && measOk) begin
			// Nearest whole cycle keeps our share of the error small
			baudStatus.divisor  <= rxCnt[15:0];
			baudStatus.detected <= 1'b1;
			autoArmed           <= 1'b0;
		end
	end

	// Transmitter: start, eight data bits LSB first, stop
	always_ff @(posedge clock) begin
		if (rst) begin
			txState      <= hut_pkg::TX_IDLE;
			txCnt        <= '0;
			txBits       <= '0;
			txShift      <= '0;
			hciSerialOut <= 1'b1;
		end else begin
			case (txState)
				hut_pkg::TX_IDLE: begin
					// Permit is checked only between characters
					if (txTake) begin
						hciSerialOut <= 1'b0;
						txShift      <= {1'b1, txqData};
						txBits       <= 4'(`HUT_FRAME_BITS);
						txCnt        <= '0;
						txState      <= hut_pkg::TX_SEND;
					end
				end
				hut_pkg::TX_SEND: begin
					if (!txBitEnd) begin
						txCnt <= txCnt + 16'd1;
					end else if (txBits == '0) begin
						// Stop bit has run its full period
						txState <= hut_pkg::TX_IDLE;
					end else begin
						txCnt        <= '0;
						hciSerialOut <= txShift[0];
						txShift      <= {1'b1, txShift[8:1]};
						txBits       <= txBits - 4'd1;
					end
				end
				default: begin
					txState      <= hut_pkg::TX_IDLE;
					hciSerialOut <= 1'b1;
				end
			endcase
		end
	end

	// Receiver, including autobaud measurement and the hunt for idle
	always_ff @(posedge clock) begin
		if (rst) begin
			rxState      <= hut_pkg::RX_IDLE;
			rxCnt        <= '0;
			rxBits       <= '0;
			rxShift      <= '0;
			rxPush       <= 1'b0;
			rxFrameError <= 1'b0;
			rxOverrun    <= 1'b0;
		end else begin
			rxPush       <= 1'b0;
			rxFrameError <= 1'b0;
			rxOverrun    <= 1'b0;
			case (rxState)
				hut_pkg::RX_IDLE: begin
					// The edge cycle is already low, so a timed start bit begins at one
					rxCnt <= (rxFall && autoArmed) ? 20'd1 : '0;
					if (rxFall) begin
						// First start bit is timed while autobaud is armed
						rxState <= autoArmed ? hut_pkg::RX_MEASURE : hut_pkg::RX_START;
					end
				end
				hut_pkg::RX_START: begin
					if (rxCnt == halfBit) begin
						rxCnt   <= '0;
						rxBits  <= '0;
						// A glitch shorter than half a bit is dropped
						rxState <= rxLine ? hut_pkg::RX_IDLE : hut_pkg::RX_DATA;
					end else begin
						rxCnt <= rxCnt + 20'd1;
					end
				end
				hut_pkg::RX_DATA: begin
					if (rxBitEnd) begin
						rxCnt   <= '0;
						rxShift <= {rxLine, rxShift[7:1]};
						rxBits  <= rxBits + 4'd1;
						if (rxBits == 4'd7) begin
							rxState <= hut_pkg::RX_STOP;
						end
					end else begin
						rxCnt <= rxCnt + 20'd1;
					end
				end
				hut_pkg::RX_STOP: begin
					// Decision taken at the stop bit midpoint
					if (rxBitEnd) begin
						rxState      <= hut_pkg::RX_IDLE;
						rxPush       <= rxLine && rxqReady;
						rxOverrun    <= rxLine && !rxqReady;
						rxFrameError <= !rxLine;
					end else begin
						rxCnt <= rxCnt + 20'd1;
					end
				end
				hut_pkg::RX_MEASURE: begin
					// Width of the low start bit is the new divisor
					if (rxLine) begin
						rxCnt   <= '0;
						rxState <= measOk ? hut_pkg::RX_HUNT : hut_pkg::RX_IDLE;
					end else if (rxCnt != 20'hFFFFF) begin
						rxCnt <= rxCnt + 20'd1;
					end
				end
				hut_pkg::RX_HUNT: begin
					// Rest of the timed character is skipped until the line idles
					if (!rxLine) begin
						rxCnt <= '0;
					end else if (rxCnt >= huntLimit) begin
						rxState <= hut_pkg::RX_IDLE;
					end else begin
						rxCnt <= rxCnt + 20'd1;
					end
				end
				default: begin
					rxState <= hut_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// Ready line: low while room remains, high near full outside three-wire mode
	always_ff @(posedge clock) begin
		if (rst) begin
			hciRxFlowReadyN <= 1'b1;
		end else begin
			hciRxFlowReadyN <= !isH5 && nearFull;
		end
	end
endmodule : hut_transport

// ### test/hut_transport_props.sv
// Checker for the host serial transport ports
`timescale 1ns/1ps
module hut_transport_props (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Observed ports
	input  wire logic         hciSerialOut,
	input  wire logic         hciRxFlowReadyN,
	input  hut_pkg::hut_mode_e transportMode,
	input  wire logic         baudWrite,
	input  wire logic [15:0]  baudDivisorIn,
	input  hut_pkg::hut_baud_s baudStatus,
	input  wire logic         rxValid,
	input  wire logic [7:0]   rxData,
	input  wire logic         rxReady,
	input  wire logic         rxFrameError,
	input  wire logic         rxOverrun
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Reset checks sit on the release edge, since rst disables everything
	pins_idle_a: assert property ($fell(rst) |-> hciSerialOut && hciRxFlowReadyN)
		else $error("Pins not idle after reset");
	rate_default_a: assert property ($fell(rst) |-> baudStatus == {1'b0, 16'h00AE})
		else $error("Rate not default after reset");
	rate_write_a: assert property (baudWrite && baudDivisorIn inside {[16'h0005:16'h0824]}
		|=> baudStatus.divisor == $past(baudDivisorIn))
		else $error("Rate write not taken");
	rate_range_a: assert property (baudWrite && !(baudDivisorIn inside {[16'h0005:16'h0824]})
		|=> $stable(baudStatus.divisor))
		else $error("Out of range rate taken");
	detect_sticky_a: assert property (baudStatus.detected |=> baudStatus.detected)
		else $error("Detection flag lost");
	h5_ready_a: assert property (transportMode == hut_pkg::HUT_H5 [*2] |-> !hciRxFlowReadyN)
		else $error("Ready line high in three wire mode");
	rx_hold_a: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
		else $error("Receive stream dropped its byte");
	overrun_ready_a: assert property (rxOverrun && transportMode != hut_pkg::HUT_H5 |-> hciRxFlowReadyN)
		else $error("Overrun while ready line low");
	frame_pulse_a: assert property (rxFrameError |=> !rxFrameError)
		else $error("Frame error longer than a cycle");
	// Main scenarios
	cover property (rxOverrun);
	cover property (rxFrameError);
	cover property ($fell(hciSerialOut));
endmodule : hut_transport_props

bind hut_transport hut_transport_props i_hut_transport_props (.clock(clock), .rst(rst),
	.hciSerialOut(hciSerialOut), .hciRxFlowReadyN(hciRxFlowReadyN), .transportMode(transportMode),
	.baudWrite(baudWrite), .baudDivisorIn(baudDivisorIn), .baudStatus(baudStatus), .rxValid(rxValid),
	.rxData(rxData), .rxReady(rxReady), .rxFrameError(rxFrameError), .rxOverrun(rxOverrun));

// ### test/hut_host_model.sv
// Host serial port model facing the transport
`timescale 1ns/1ps
module hut_host_model (
	// Clock and bit length in cycles
	input  wire logic clock,
	input  int        div,
	// Serial pins
	input  wire logic hciSerialOut,
	output logic      hciSerialIn,
	output logic      hciTxFlowPermitN
);
	logic [7:0] got[$]; // Bytes decoded from the device
	logic [7:0] sh;     // Receive shift
	initial begin
		hciSerialIn = 1'b1;
		hciTxFlowPermitN = 1'b0;
	end
	// Permit changes only between calls, off the sampling edge
	task automatic setPermit(input logic v);
		hciTxFlowPermitN = v;
	endtask : setPermit
	// One character; a low stop bit is for error tests only
	task automatic send(input logic [7:0] b, input logic stopBit);
		logic [9:0] f;
		f = {stopBit, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			hciSerialIn = f[i];
			repeat (div) @(negedge clock);
		end
		// Line must return high before the next start
		if (!stopBit) begin
			hciSerialIn = 1'b1;
			repeat (div) @(negedge clock);
		end
	endtask : send
	// Decode device characters at bit centres
	always begin
		@(negedge hciSerialOut);
		repeat (div + div / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			sh[i] = hciSerialOut;
			repeat (div) @(posedge clock);
		end
		if (hciSerialOut === 1'b1) got.push_back(sh);
	end
endmodule : hut_host_model

// ### test/testbench.sv
// Self-checking bench for the host serial transport
`timescale 1ns/1ps
module testbench;
	logic        clock, rst, hciSerialIn, hciTxFlowPermitN, hciSerialOut, hciRxFlowReadyN;
	logic        baudWrite, txValid, txReady, rxValid, rxReady, rxFrameError, rxOverrun;
	logic        feSeen, ovSeen;
	logic [15:0] baudDivisorIn;
	logic [7:0]  txData, rxData, d;
	int          errors, compares, hostDiv, n;
	hut_pkg::hut_mode_e transportMode;
	hut_pkg::hut_baud_s baudStatus;
	// Small queue keeps the fill test short
	hut_transport #(.DEPTH(16), .RTS_MARGIN(4)) i_hut_transport (.clock(clock), .rst(rst),
		.hciSerialIn(hciSerialIn), .hciTxFlowPermitN(hciTxFlowPermitN), .hciSerialOut(hciSerialOut),
		.hciRxFlowReadyN(hciRxFlowReadyN), .transportMode(transportMode), .baudWrite(baudWrite),
		.baudDivisorIn(baudDivisorIn), .baudStatus(baudStatus), .txValid(txValid), .txData(txData),
		.txReady(txReady), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
		.rxFrameError(rxFrameError), .rxOverrun(rxOverrun));
	hut_host_model i_hut_host_model (.clock(clock), .div(hostDiv), .hciSerialOut(hciSerialOut),
		.hciSerialIn(hciSerialIn), .hciTxFlowPermitN(hciTxFlowPermitN));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Pulses are caught here so tasks need not watch every edge
	always @(posedge clock) begin
		if (rst) begin
			feSeen <= 1'b0;
			ovSeen <= 1'b0;
		end
		if (rxFrameError === 1'b1) feSeen <= 1'b1;
		if (rxOverrun === 1'b1) ovSeen <= 1'b1;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	// One-cycle rate write pulse
	task automatic wr(input logic [15:0] v);
		baudDivisorIn = v;
		baudWrite = 1'b1;
		@(negedge clock);
		baudWrite = 0;
		@(negedge clock);
	endtask : wr
	// Transport selection, changed only off the sampling edge
	task automatic setMode(input hut_pkg::hut_mode_e m);
		transportMode = m;
	endtask : setMode
	// Controller push, held until taken
	task automatic push(input logic [7:0] b);
		txData = b;
		txValid = 1'b1;
		@(posedge clock);
		while (txReady !== 1'b1) @(posedge clock);
		@(negedge clock);
		txValid = 1'b0;
	endtask : push
	// Controller pop with rxReady already high; X on timeout
	task automatic pop(output logic [7:0] b);
		for (int i = 0; i < 400; i++) begin
			@(posedge clock);
			if (rxValid === 1'b1) break;
		end
		b = (rxValid === 1'b1) ? rxData : 8'hXX;
		@(negedge clock);
	endtask : pop
	task automatic t_reset;
		chk("out idle", hciSerialOut, 1'h1);
		chk("ready", hciRxFlowReadyN, 1'h0);
		chk("txReady", txReady, 1'h1);
		chk("status", baudStatus, {1'b0, 16'h00AE});
		$display("reset test done");
	endtask : t_reset
	// Start bit alone is low, so its width is the bit length
	task automatic t_auto;
		hostDiv = 20;
		i_hut_host_model.send(8'h01, 1'b1);
		repeat (220) @(negedge clock);
		chk("detect", baudStatus, {1'b1, 16'h0014});
		$display("autobaud test done");
	endtask : t_auto
	task automatic t_rate;
		wr(16'h0004);
		chk("low rate", baudStatus.divisor, 16'h0014);
		wr(16'h0825);
		chk("high rate", baudStatus.divisor, 16'h0014);
		wr(16'h000A);
		chk("new rate", baudStatus.divisor, 16'h000A);
		hostDiv = 10;
		$display("rate test done");
	endtask : t_rate
	// Extended H4 still honours the permit line
	task automatic t_tx;
		setMode(hut_pkg::HUT_H4X);
		i_hut_host_model.setPermit(1'b1);
		repeat (10) @(negedge clock);
		push(8'hA5);
		@(negedge clock);
		push(8'h3C);
		repeat (300) @(negedge clock);
		chk("held", i_hut_host_model.got.size(), 32'h0);
		i_hut_host_model.setPermit(1'b0);
		n = 0;
		while (hciSerialOut === 1'b1 && n < 40) begin
			@(negedge clock);
			n++;
		end
		chk("start delay", n <= 15, 1'h1);
		for (int i = 0; i < 300 && i_hut_host_model.got.size() < 2; i++) @(negedge clock);
		chk("byte0", i_hut_host_model.got[0], 8'hA5);
		chk("byte1", i_hut_host_model.got[1], 8'h3C);
		setMode(hut_pkg::HUT_H4);
		$display("transmit test done");
	endtask : t_tx
	task automatic t_rx;
		rxReady = 1'b1;
		i_hut_host_model.send(8'h5A, 1'b1);
		pop(d);
		chk("rx byte", d, 8'h5A);
		rxReady = 1'b0;
		i_hut_host_model.send(8'hC3, 1'b0);
		repeat (30) @(negedge clock);
		chk("frame error", feSeen, 1'h1);
		chk("dropped", rxValid, 1'h0);
		$display("receive test done");
	endtask : t_rx
	// Overfill with the controller stalled, then three wire mode, then drain
	task automatic t_flow;
		for (int i = 0; i < 20; i++) i_hut_host_model.send(8'(i), 1'b1);
		chk("ready high", hciRxFlowReadyN, 1'h1);
		chk("overrun", ovSeen, 1'h1);
		setMode(hut_pkg::HUT_H5);
		i_hut_host_model.setPermit(1'b1);
		repeat (3) @(negedge clock);
		chk("h5 ready", hciRxFlowReadyN, 1'h0);
		push(8'h81);
		for (int i = 0; i < 300 && i_hut_host_model.got.size() < 3; i++) @(negedge clock);
		chk("h5 tx", i_hut_host_model.got[2], 8'h81);
		setMode(hut_pkg::HUT_H4);
		i_hut_host_model.setPermit(1'b0);
		rxReady = 1'b1;
		n = 0;
		for (int i = 0; i < 20; i++) begin
			pop(d);
			if (d !== 8'(i)) break;
			n++;
		end
		// Sixteen stored plus the one in the output stage
		chk("kept", n, 32'h11);
		rxReady = 1'b0;
		repeat (3) @(negedge clock);
		chk("ready low", hciRxFlowReadyN, 1'h0);
		$display("flow test done");
	endtask : t_flow
	// Watchdog well past the expected run
	initial begin
		repeat (30000) @(posedge clock);
		errors++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		{baudWrite, txValid, rxReady} = 3'h0;
		baudDivisorIn = 16'h0000;
		txData = 8'h00;
		setMode(hut_pkg::HUT_H4);
		errors = 0;
		compares = 0;
		hostDiv = 174;
		repeat (10) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		t_reset();
		t_auto();
		t_rate();
		t_tx();
		t_rx();
		t_flow();
		report_and_stop();
	end
endmodule : testbench
